// [pkg/otd_pkg.sv]
// Purpose: Shared constants and types for the option and trim byte decoder.
// Assumes: Byte-wide flash read port and byte-wide CPU register file port.
// Notes: Reserved option and trim bits are erased ones; the decode never looks at them.
package otd_pkg;

    // CPU register file addresses of the trim index and trim value registers.
    localparam logic [11:0] OTD_TRIM_INDEX_ADDR = 12'hFF6;
    localparam logic [11:0] OTD_TRIM_VALUE_ADDR = 12'hFF7;

    // Flash locations: second user option byte and the first trim byte.
    localparam logic [15:0] OTD_OPTION_ADDR = 16'h0001;
    localparam logic [15:0] OTD_TRIM_BASE_ADDR = 16'h0020;

    // Number of trim bytes in the information page window.
    localparam int OTD_TRIM_BYTES = 32;

    // Trim byte indices that drive analog adjustments.
    localparam int OTD_IDX_TEMP_FINE = 0;
    localparam int OTD_IDX_TEMP_COARSE = 1;
    localparam int OTD_IDX_OSC = 2;
    localparam int OTD_IDX_LOW_VOLT = 3;
    localparam int OTD_IDX_BAND_GAP = 4;

    // Field positions inside the option and trim bytes.
    localparam int OTD_CRYSTAL_OFF_BIT = 4;
    localparam int OTD_FINE_LSB = 4;
    localparam int OTD_FINE_W = 4;
    localparam int OTD_ULTRA_W = 3;
    localparam int OTD_COARSE_W = 5;
    localparam int OTD_OSC_W = 8;
    localparam int OTD_LVD_W = 5;
    localparam int OTD_BG_W = 6;

    // Working copy values used before the flash has been read.
    localparam logic [7:0] OTD_OPTION_RESET = 8'hFF;
    localparam logic [7:0] OTD_TRIM_RESET = 8'hFF;
    localparam logic [7:0] OTD_LVD_RESET = 8'hE4;

    // Low-voltage threshold arithmetic, in millivolts.
    localparam logic [11:0] OTD_LVD_BASE_MV = 12'hC80;
    localparam logic [11:0] OTD_LVD_STEP_MV = 12'h032;

    // Decoded working trim fields handed to the analog blocks.
    typedef struct packed {
        logic [3:0] temp_fine_offset;
        logic [2:0] temp_ultra_offset;
        logic [4:0] temp_coarse_offset;
        logic [7:0] precision_osc_adjust;
        logic [4:0] low_voltage_threshold_adjust;
        logic [11:0] low_voltage_level;
        logic [5:0] band_gap_adjust;
    } otd_trim_fields_type;

    // Raw working bytes that feed the decoder.
    typedef struct packed {
        logic [7:0] temp_sensor_fine_trim;
        logic [7:0] temp_sensor_coarse_trim;
        logic [7:0] oscillator_trim;
        logic [7:0] low_voltage_trim;
        logic [7:0] band_gap_trim;
    } otd_trim_bytes_type;

endpackage : otd_pkg

// [hw/otd_trim_decode.sv]
// Purpose: Splits the working trim bytes into the analog adjustment fields.
// Assumes: Bytes come from flops on the same clock.
// Notes: Outputs are registered so the analog side sees glitch-free codes.
`timescale 1ns/1ps
module otd_trim_decode
    import otd_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Working trim bytes.
    input wire otd_trim_bytes_type trim_bytes,
    // Decoded fields.
    output otd_trim_fields_type trim_fields
);

    // Threshold in millivolts: base minus code times the step.
    function automatic logic [11:0] otd_lvd_mv(input logic [4:0] code);
        logic [11:0] drop;
        drop = 12'(code) * OTD_LVD_STEP_MV;
        return OTD_LVD_BASE_MV - drop;
    endfunction : otd_lvd_mv

    // Field extraction; reserved bits are simply not picked up.
    otd_trim_fields_type fields_next;
    otd_trim_fields_type fields_reset;
    wire logic [4:0] lvd_code = trim_bytes.low_voltage_trim[OTD_LVD_W-1:0];

    assign fields_next.temp_fine_offset =
        trim_bytes.temp_sensor_fine_trim[OTD_FINE_LSB +: OTD_FINE_W];
    assign fields_next.temp_ultra_offset =
        trim_bytes.temp_sensor_fine_trim[OTD_ULTRA_W-1:0];
    assign fields_next.temp_coarse_offset =
        trim_bytes.temp_sensor_coarse_trim[OTD_COARSE_W-1:0];
    assign fields_next.precision_osc_adjust =
        trim_bytes.oscillator_trim[OTD_OSC_W-1:0];
    assign fields_next.low_voltage_threshold_adjust = lvd_code;
    assign fields_next.low_voltage_level = otd_lvd_mv(lvd_code);
    assign fields_next.band_gap_adjust =
        trim_bytes.band_gap_trim[OTD_BG_W-1:0];

    // Reset view matches the working bytes' reset values.
    assign fields_reset.temp_fine_offset = OTD_TRIM_RESET[OTD_FINE_LSB +: OTD_FINE_W];
    assign fields_reset.temp_ultra_offset = OTD_TRIM_RESET[OTD_ULTRA_W-1:0];
    assign fields_reset.temp_coarse_offset = OTD_TRIM_RESET[OTD_COARSE_W-1:0];
    assign fields_reset.precision_osc_adjust = OTD_TRIM_RESET[OTD_OSC_W-1:0];
    assign fields_reset.low_voltage_threshold_adjust = OTD_LVD_RESET[OTD_LVD_W-1:0];
    assign fields_reset.low_voltage_level = otd_lvd_mv(OTD_LVD_RESET[OTD_LVD_W-1:0]);
    assign fields_reset.band_gap_adjust = OTD_TRIM_RESET[OTD_BG_W-1:0];

    // Output register.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trim_fields <= fields_reset;
        end else begin
            trim_fields <= fields_next;
        end
    end

endmodule : otd_trim_decode

// [hw/otd_option_trim_loader.sv]
// Purpose: Loads option and trim bytes from flash at every reset and decodes them.
// Assumes: Flash read port and CPU register port run on ref_clk; no sync needed.
// Notes: Flash is only ever read here; the working copies live in flops.
`timescale 1ns/1ps
module otd_option_trim_loader
    import otd_pkg::*;
#(
    parameter int TRIM_BYTES = OTD_TRIM_BYTES
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Stop-mode recovery request, one cycle, from the power controller.
    input wire logic stop_recovery,
    // Flash read port.
    output logic flash_rd_req,
    output logic flash_rd_info,
    output logic [15:0] flash_rd_addr,
    input wire logic flash_rd_ack,
    input wire logic [7:0] flash_rd_data,
    // CPU register file port.
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic reg_hit,
    output logic [7:0] reg_rdata,
    // Reset sequencing and oscillator control.
    output logic cpu_hold,
    output logic crystal_osc_enable,
    output logic crystal_off_in_reset,
    // Decoded working trim fields.
    output otd_trim_fields_type trim_fields
);

    localparam int IDX_W = $clog2(TRIM_BYTES);

    // The index register is eight bits wide and the fixed decode needs bytes 0 to 4.
    // The size is refused at elaboration, so no run ever starts with a window it cannot serve.
    if (TRIM_BYTES < 5 || TRIM_BYTES > 256) begin : g_size_check
        $error("TRIM_BYTES must lie between 5 and 256");
    end

    // Loader states, one-hot.
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_OPTION = 4'b0010,
        ST_TRIM = 4'b0100,
        ST_RUN = 4'b1000
    } otd_state_type;

    // Maps a trim index to its information page location.
    function automatic logic [15:0] otd_trim_location(input logic [IDX_W-1:0] idx);
        return OTD_TRIM_BASE_ADDR + 16'(idx);
    endfunction : otd_trim_location

    // True when an index addresses an existing trim byte.
    function automatic logic otd_index_valid(input logic [7:0] idx);
        return 9'(idx) < 9'(TRIM_BYTES);
    endfunction : otd_index_valid

    otd_state_type state_reg;
    otd_state_type state_next;
    logic [IDX_W-1:0] load_idx_reg;
    logic [IDX_W-1:0] load_idx_next;
    logic [7:0] option_reg;
    logic [7:0] option_next;
    logic [7:0] index_reg;
    logic [7:0] index_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] trim_mem [TRIM_BYTES];
    otd_trim_bytes_type trim_bytes;

    // State decode.
    wire logic in_reset = state_reg == ST_RESET;
    wire logic in_option = state_reg == ST_OPTION;
    wire logic in_trim = state_reg == ST_TRIM;
    wire logic in_run = state_reg == ST_RUN;
    wire logic last_idx = load_idx_reg == IDX_W'(TRIM_BYTES - 1);

    // Flash captures during the load sequence.
    wire logic option_take = in_option && flash_rd_ack;
    wire logic trim_take = in_trim && flash_rd_ack;

    // CPU register decode; the port is refused while a load is running.
    wire logic sel_index = reg_addr == OTD_TRIM_INDEX_ADDR;
    wire logic sel_value = reg_addr == OTD_TRIM_VALUE_ADDR;
    wire logic cpu_ok = in_run;
    wire logic index_wr = cpu_ok && reg_wr && sel_index;
    wire logic value_wr = cpu_ok && reg_wr && sel_value && otd_index_valid(index_reg);
    wire logic any_rd = cpu_ok && reg_rd;
    wire logic [IDX_W-1:0] cpu_idx = index_reg[IDX_W-1:0];

    // Read data: the byte picked by the index, or zero when out of range.
    wire logic [7:0] value_rd_data = otd_index_valid(index_reg) ? trim_mem[cpu_idx] : 8'h00;

    // Working memory write port, shared by loader and CPU.
    wire logic mem_we = trim_take || value_wr;
    wire logic [IDX_W-1:0] mem_waddr = trim_take ? load_idx_reg : cpu_idx;
    wire logic [7:0] mem_wdata = trim_take ? flash_rd_data : reg_wdata;

    // Next-state logic of the loader.
    always_comb begin
        state_next = state_reg;
        load_idx_next = load_idx_reg;
        case (state_reg)
            ST_RESET: begin
                state_next = ST_OPTION;
                load_idx_next = '0;
            end
            ST_OPTION: begin
                if (flash_rd_ack) begin
                    state_next = ST_TRIM;
                end
            end
            ST_TRIM: begin
                if (flash_rd_ack) begin
                    if (last_idx) begin
                        state_next = ST_RUN;
                    end else begin
                        load_idx_next = load_idx_reg + IDX_W'(1);
                    end
                end
            end
            ST_RUN: begin
                if (stop_recovery) begin
                    state_next = ST_OPTION;
                    load_idx_next = '0;
                end
            end
            default: begin
                state_next = ST_RESET;
                load_idx_next = '0;
            end
        endcase
    end

    // Loader state registers; any reset restarts the reload.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
            load_idx_reg <= '0;
        end else begin
            state_reg <= state_next;
            load_idx_reg <= load_idx_next;
        end
    end

    // Option working copy, captured from the flash at each load.
    assign option_next = option_take ? flash_rd_data : option_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            option_reg <= OTD_OPTION_RESET;
        end else begin
            option_reg <= option_next;
        end
    end

    // Trim index register, software visible.
    assign index_next = index_wr ? reg_wdata : index_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            index_reg <= 8'h00;
        end else begin
            index_reg <= index_next;
        end
    end

    // Read data register, updated on every read while running; unmapped addresses load zero.
    assign rdata_next = !any_rd ? rdata_reg :
                        sel_index ? index_reg :
                        sel_value ? value_rd_data : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Working trim bytes; reloaded from flash, the flash itself is never written.
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            trim_mem[mem_waddr] <= mem_wdata;
        end
    end

    // Bytes that feed the fixed analog decode.
    assign trim_bytes.temp_sensor_fine_trim = trim_mem[OTD_IDX_TEMP_FINE];
    assign trim_bytes.temp_sensor_coarse_trim = trim_mem[OTD_IDX_TEMP_COARSE];
    assign trim_bytes.oscillator_trim = trim_mem[OTD_IDX_OSC];
    assign trim_bytes.low_voltage_trim = trim_mem[OTD_IDX_LOW_VOLT];
    assign trim_bytes.band_gap_trim = trim_mem[OTD_IDX_BAND_GAP];

    // Decoded fields are held at their reset view until the trim bytes are loaded.
    otd_trim_fields_type decoded_fields;
    logic trim_loaded_reg;

    // Marks that the working bytes hold flash contents.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trim_loaded_reg <= 1'b0;
        end else if (trim_take && last_idx) begin
            trim_loaded_reg <= 1'b1;
        end
    end

    otd_trim_decode u_decode (
        .ref_clk(ref_clk),
        .rst_n(rst_n && trim_loaded_reg),
        .trim_bytes(trim_bytes),
        .trim_fields(decoded_fields)
    );

    assign trim_fields = decoded_fields;

    // Flash request: option byte first, then the trim bytes in order.
    assign flash_rd_req = in_option || in_trim;
    assign flash_rd_info = in_trim;
    assign flash_rd_addr = in_trim ? otd_trim_location(load_idx_reg) : OTD_OPTION_ADDR;

    // CPU stays held until the whole load has finished.
    assign cpu_hold = !in_run;

    // Crystal runs during reset only when the option bit is clear.
    assign crystal_off_in_reset = option_reg[OTD_CRYSTAL_OFF_BIT];
    assign crystal_osc_enable = !in_run && !crystal_off_in_reset;

    // Only the enable is driven here; clock source selection stays with software.
    // No clock-select output exists in this block.

    // Register port answers.
    assign reg_hit = sel_index || sel_value;
    assign reg_rdata = rdata_reg;

    // Through a load after reset the decoded outputs and read data hold reset values, but not through a stop-recovery reload;
    // reserved bits of every byte are ignored by the decode.

endmodule : otd_option_trim_loader

// [verification/otd_properties.sv]
// Purpose: Port-level timing checks for the option and trim loader.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every loader instance; prints nothing but failures.
`timescale 1ns/1ps
module otd_properties
    import otd_pkg::*;
#(
    parameter int TRIM_BYTES = OTD_TRIM_BYTES
)
(
    // Clock, reset and stop recovery.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic stop_recovery,
    // Flash read port.
    input wire logic flash_rd_req,
    input wire logic flash_rd_info,
    input wire logic [15:0] flash_rd_addr,
    input wire logic flash_rd_ack,
    input wire logic [7:0] flash_rd_data,
    // Register port.
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_hit,
    input wire logic [7:0] reg_rdata,
    // Sequencing and decoded outputs.
    input wire logic cpu_hold,
    input wire logic crystal_osc_enable,
    input wire logic crystal_off_in_reset,
    input wire otd_trim_fields_type trim_fields
);
    // The last trim location and the flash handshake, shared by the load checks.
    wire logic [15:0] last_addr = OTD_TRIM_BASE_ADDR + 16'(TRIM_BYTES - 1);
    wire logic took = flash_rd_req && flash_rd_ack;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_load_starts; $rose(rst_n) |=> flash_rd_req && !flash_rd_info && flash_rd_addr == OTD_OPTION_ADDR; endproperty
    a_load_starts: assert property (p_load_starts) else $error("load did not open with the option byte");
    property p_reset_view; $rose(rst_n) |=> trim_fields.low_voltage_threshold_adjust == 5'h04; endproperty
    a_reset_view: assert property (p_reset_view) else $error("threshold trim reset code wrong");
    property p_trim_base; took && !flash_rd_info |=> flash_rd_info && flash_rd_addr == OTD_TRIM_BASE_ADDR; endproperty
    a_trim_base: assert property (p_trim_base) else $error("first trim read not at base");
    property p_trim_step; took && flash_rd_info && flash_rd_addr != last_addr |=> flash_rd_req
        && flash_rd_addr == $past(flash_rd_addr) + 16'h0001; endproperty
    a_trim_step: assert property (p_trim_step) else $error("trim reads not consecutive");
    property p_load_done; took && flash_rd_info && flash_rd_addr == last_addr |=> !cpu_hold && !flash_rd_req; endproperty
    a_load_done: assert property (p_load_done) else $error("cpu not released after last trim byte");
    property p_req_holds; flash_rd_req && !flash_rd_ack |=> flash_rd_req && $stable(flash_rd_addr); endproperty
    a_req_holds: assert property (p_req_holds) else $error("flash request dropped before answer");
    property p_option_copy; took && !flash_rd_info |=> crystal_off_in_reset == $past(flash_rd_data[4]); endproperty
    a_option_copy: assert property (p_option_copy) else $error("crystal option not loaded");
    property p_crystal_en; crystal_osc_enable == (cpu_hold && !crystal_off_in_reset); endproperty
    a_crystal_en: assert property (p_crystal_en) else $error("crystal enable disagrees with option");
    property p_no_switch; $fell(cpu_hold) |-> !crystal_osc_enable [*2]; endproperty
    a_no_switch: assert property (p_no_switch) else $error("crystal kept on after reset");
    property p_level; trim_fields.low_voltage_level == 12'h0C80
        - 12'(trim_fields.low_voltage_threshold_adjust) * 12'h0032; endproperty
    a_level: assert property (p_level) else $error("threshold level arithmetic wrong");
    property p_hit; reg_hit == (reg_addr == OTD_TRIM_INDEX_ADDR || reg_addr == OTD_TRIM_VALUE_ADDR); endproperty
    a_hit: assert property (p_hit) else $error("register decode wrong");
    property p_stray_read; reg_rd && !reg_hit && !cpu_hold |=> reg_rdata == 8'h00; endproperty
    a_stray_read: assert property (p_stray_read) else $error("unmapped read not zero");
endmodule : otd_properties

bind otd_option_trim_loader otd_properties #(.TRIM_BYTES(TRIM_BYTES)) otd_properties_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .stop_recovery(stop_recovery), .flash_rd_req(flash_rd_req),
    .flash_rd_info(flash_rd_info), .flash_rd_addr(flash_rd_addr), .flash_rd_ack(flash_rd_ack),
    .flash_rd_data(flash_rd_data), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_hit(reg_hit), .reg_rdata(reg_rdata), .cpu_hold(cpu_hold), .crystal_osc_enable(crystal_osc_enable),
    .crystal_off_in_reset(crystal_off_in_reset), .trim_fields(trim_fields));

// [verification/testbench.sv]
// Purpose: Self-checking bench for the option and trim loader.
// Assumes: Bench plays flash and CPU; trim window shortened to five bytes.
// Notes: Random contents from a fixed xorshift seed, with threshold corners.
`timescale 1ns/1ps
module testbench
    import otd_pkg::*;
();
    localparam int NB = 5;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic stop_recovery = 1'b0;
    logic flash_rd_ack = 1'b0;
    logic [7:0] flash_rd_data = 8'h00;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic flash_rd_req, flash_rd_info, reg_hit, cpu_hold, crystal_osc_enable, crystal_off_in_reset;
    logic [15:0] flash_rd_addr;
    logic [7:0] reg_rdata, q, v;
    otd_trim_fields_type trim_fields;
    logic [7:0] opt_byte = 8'hFF;
    logic [7:0] mem [NB];
    logic [31:0] seed = 32'h0000_C6F9;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // Free-running 40 MHz clock.
    always #12.5 ref_clk = ~ref_clk;

    otd_option_trim_loader #(.TRIM_BYTES(NB)) otd_option_trim_loader_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .stop_recovery(stop_recovery), .flash_rd_req(flash_rd_req),
        .flash_rd_info(flash_rd_info), .flash_rd_addr(flash_rd_addr), .flash_rd_ack(flash_rd_ack),
        .flash_rd_data(flash_rd_data), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_hit(reg_hit), .reg_rdata(reg_rdata), .cpu_hold(cpu_hold),
        .crystal_osc_enable(crystal_osc_enable), .crystal_off_in_reset(crystal_off_in_reset),
        .trim_fields(trim_fields));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Expected decode of the stored bytes, with byte three given separately.
    function automatic otd_trim_fields_type exp_f(input logic [7:0] b3);
        otd_trim_fields_type f;
        f.temp_fine_offset = mem[0][7:4];
        f.temp_ultra_offset = mem[0][2:0];
        f.temp_coarse_offset = mem[1][4:0];
        f.precision_osc_adjust = mem[2];
        f.low_voltage_threshold_adjust = b3[4:0];
        f.low_voltage_level = 12'h0C80 - 12'(b3[4:0]) * 12'h0032;
        f.band_gap_adjust = mem[4][5:0];
        return f;
    endfunction : exp_f

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One register access; read data is taken 1 ns after the edge that samples the strobe.
    task automatic reg_op(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr <= w;
        reg_rd <= !w;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask : reg_op

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Flash answers after a random wait and scrambles its data lines while idle.
    always @(posedge ref_clk) begin
        if (flash_rd_req && !flash_rd_ack && (xs() & 32'h0000_0001) != 0) begin
            flash_rd_ack <= 1'b1;
            flash_rd_data <= flash_rd_info ? mem[flash_rd_addr - OTD_TRIM_BASE_ADDR] : opt_byte;
        end else begin
            flash_rd_ack <= 1'b0;
            flash_rd_data <= ~flash_rd_data;
        end
    end

    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    // Even rounds load fresh contents by reset; odd rounds reload the same ones by stop recovery.
    initial begin
        for (int r = 0; r < 4; r++) begin
            @(posedge ref_clk);
            if (r % 2 == 0) begin
                opt_byte = 8'(xs());
                opt_byte[4] = (r == 2);
                for (int i = 0; i < NB; i++) mem[i] = 8'(xs());
                mem[3] = (r == 0) ? 8'hE0 : 8'hFF;
                rst_n <= 1'b0;
                repeat (3) @(posedge ref_clk);
                rst_n <= 1'b1;
                @(posedge ref_clk);
                #1 chk("reset threshold code", 5'h04, trim_fields.low_voltage_threshold_adjust);
            end else begin
                stop_recovery <= 1'b1;
                @(posedge ref_clk);
                stop_recovery <= 1'b0;
                @(posedge ref_clk);
                #1;
            end
            for (int k = 0; k < 200 && cpu_hold !== 1'b0; k++) begin
                @(posedge ref_clk);
                #1;
            end
            chk("crystal option", opt_byte[4], crystal_off_in_reset);
            chk("crystal enable in run", 1'b0, crystal_osc_enable);
            repeat (2) @(posedge ref_clk);
            #1 chk("decoded fields", exp_f(mem[3]), trim_fields);
            for (int i = 0; i < NB; i++) begin
                reg_op(OTD_TRIM_INDEX_ADDR, 1'b1, 8'(i), q);
                reg_op(OTD_TRIM_VALUE_ADDR, 1'b0, 8'h00, q);
                chk("trim byte", mem[i], q);
            end
            v = 8'(xs());
            reg_op(OTD_TRIM_INDEX_ADDR, 1'b1, 8'h03, q);
            reg_op(OTD_TRIM_VALUE_ADDR, 1'b1, v, q);
            @(posedge ref_clk);
            #1 chk("written threshold", exp_f(v), trim_fields);
            reg_op(OTD_TRIM_INDEX_ADDR, 1'b1, 8'h20, q);
            reg_op(OTD_TRIM_VALUE_ADDR, 1'b1, 8'h5A, q);
            reg_op(OTD_TRIM_VALUE_ADDR, 1'b0, 8'h00, q);
            chk("out of range read", 8'h00, q);
            reg_op(OTD_TRIM_INDEX_ADDR, 1'b0, 8'h00, q);
            chk("index readback", 8'h20, q);
            chk("index hit", 1'b1, reg_hit);
            reg_op(12'h123, 1'b0, 8'h00, q);
            chk("unmapped read", 8'h00, q);
            chk("unmapped hit", 1'b0, reg_hit);
        end
        print_verdict();
    end
endmodule : testbench
